/* File: src/ddr_link_pkg.sv */
// Constants, states and helpers shared by both ends of the DDR command/address link.
// Assumes a 100 MHz system clock and a link clock made by the host end.
package ddr_link_pkg;

  // Timing of the host-made link clock.
  localparam int CLK_NS     = 10;
  localparam int CK_HALF_NS = 40;
  localparam int CK_HALF    = (CK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CK_MID     = CK_HALF / 2;

  // Transaction framing, counted in link clock edges; LAT_CYCLES is in link clock cycles.
  localparam int CA_EDGES   = 6;
  localparam int ROW_EDGE   = 4;
  localparam int LAT_CYCLES = 3;

  // Command/address word fields.
  localparam int BIT_RW     = 47;
  localparam int BIT_SPACE  = 46;
  localparam int BIT_BURST  = 45;
  localparam int ROW_HI     = 44;
  localparam int ROW_LO     = 16;
  localparam int COL_HI     = 2;
  localparam int GROUP_BITS = 3;

  // Device register space word index.
  localparam logic REG_CFG_IDX = 1'b1;

  // Host controller register offsets and fields.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int CTRL_GO     = 0;
  localparam int CTRL_READ   = 1;
  localparam int CTRL_SPACE  = 2;
  localparam int CTRL_LINEAR = 3;
  localparam int WD_MASK_A   = 17;
  localparam int WD_MASK_B   = 16;
  localparam int ST_BUSY     = 0;
  localparam int ST_REFRESH  = 1;

  typedef enum {D_IDLE, D_CA, D_LAT, D_DATA} dev_state_t;
  typedef enum {H_IDLE, H_CLK, H_WAIT} host_state_t;

  // Edge index after which the first data byte moves.
  function automatic logic [7:0] data_start(input logic refresh);
    data_start = 8'(ROW_EDGE + 2 * (refresh ? 2 * LAT_CYCLES : LAT_CYCLES));
  endfunction

  // Word address of the next word of a burst.
  function automatic logic [31:0] next_word(input logic [31:0] a, input logic linear);
    logic [GROUP_BITS-1:0] low;
    low = a[GROUP_BITS-1:0] + 1'b1;
    next_word = linear ? a + 32'h1 : {a[31:GROUP_BITS], low};
  endfunction

endpackage

/* File: src/ddr_link_if.sv */
// Link between the host controller and the memory device.
// Assumes each party drives only its own signals; two-way pins resolve here.
interface ddr_link_if;
  logic       cs_n;
  logic       bus_clock;
  logic       bus_clock_complement;
  logic [7:0] h_dq;
  logic       h_dq_oe;
  logic       h_ds;
  logic       h_ds_oe;
  logic [7:0] d_dq;
  logic       d_dq_oe;
  logic       d_ds;
  logic       d_ds_oe;
  logic [7:0] dq;
  logic       rw_data_strobe;

  // An undriven line reads low.
  assign dq             = h_dq_oe ? h_dq : (d_dq_oe ? d_dq : 8'h00);
  assign rw_data_strobe = h_ds_oe ? h_ds : (d_ds_oe & d_ds);

  modport host (
    output cs_n, bus_clock, bus_clock_complement, h_dq, h_dq_oe, h_ds, h_ds_oe,
    input  dq, rw_data_strobe
  );
  modport dev (
    input  cs_n, bus_clock, bus_clock_complement, dq, rw_data_strobe,
    output d_dq, d_dq_oe, d_ds, d_ds_oe
  );
endinterface

/* File: src/pin_sync.sv */
// Two-flop synchroniser for a bundle of pins.
// Assumes the bits of the bundle are stable around the edges that matter.
module pin_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // System
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* File: src/ddr_mem_device.sv */
// Memory device end: command/address capture, decode and a small data array.
// Assumes the link clock comes from the host and is sampled by hclk.
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
module ddr_mem_device
  #(
  parameter int          MEM_AW    = 8,
  // Identification value is arbitrary.
  parameter logic [15:0] ID_VALUE  = 16'h5a01,
  parameter logic [15:0] CFG_RESET = 16'h0000
) (
  // System
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Link
  ddr_link_if.dev          bus,
  // User side
  input  wire logic        refresh_req,
  output logic             cmd_valid,
  output logic             cmd_read,
  output logic             cmd_reg,
  output logic             cmd_linear,
  output logic      [31:0] cmd_word_addr,
  output logic             cmd_abort,
  output logic      [15:0] cfg_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic       cs_s;
  logic       ck_s;
  logic       ds_s;
  logic [7:0] dq_s;
  logic       ck_prev_q;

  pin_sync #(
    .W    (11),
    .INIT (11'h400)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({bus.cs_n, bus.bus_clock, bus.rw_data_strobe, bus.dq}),
    .q     ({cs_s, ck_s, ds_s, dq_s})
  );

  // Both clock edges move a byte; the complement clock is redundant here.
  wire link_edge = (ck_s != ck_prev_q) & !cs_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command capture and decode.

  ddr_link_pkg::dev_state_t st_q;
  logic [47:0]              ca_q;
  logic [7:0]               cnt_q;
  logic                     refresh_q;
  logic                     rd_q;
  logic                     space_q;
  logic                     lin_q;
  logic [31:0]              addr_q;
  logic                     phase_q;
  logic [7:0]               hi_q;
  logic                     hi_en_q;
  logic [7:0]               dq_q;
  logic                     dq_oe_q;
  logic                     ds_q;
  logic                     ds_oe_q;
  logic [15:0]              cfg_q;
  logic [15:0]              mem_q [2**MEM_AW];

  wire [47:0] ca_next   = {ca_q[39:0], dq_s};
  wire [7:0]  cnt_next  = cnt_q + 8'h01;
  wire        ca_done   = link_edge & (cnt_next == 8'(ddr_link_pkg::CA_EDGES));
  wire        lat_done  = link_edge & (cnt_next == ddr_link_pkg::data_start(refresh_q));
  wire        dec_read  = ca_next[ddr_link_pkg::BIT_RW];
  wire        dec_space = ca_next[ddr_link_pkg::BIT_SPACE];
  wire        dec_lin   = ca_next[ddr_link_pkg::BIT_BURST];
  // Reserved bits 15..3 are dropped; upper bits are row and half-page.
  wire [31:0] dec_addr  = {ca_next[ddr_link_pkg::ROW_HI:ddr_link_pkg::ROW_LO],
                           ca_next[ddr_link_pkg::COL_HI:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Data path selection.

  wire              in_data  = (st_q == ddr_link_pkg::D_DATA);
  wire              data_edg = in_data & link_edge;
  wire [MEM_AW-1:0] mem_idx  = addr_q[MEM_AW-1:0];
  wire              cfg_sel  = (addr_q[0] == ddr_link_pkg::REG_CFG_IDX);
  wire [15:0]       reg_word = cfg_sel ? cfg_q : ID_VALUE;
  wire [15:0]       rd_word  = space_q ? reg_word : mem_q[mem_idx];
  wire              wr_word  = data_edg & phase_q & !rd_q;
  wire              lo_en    = !ds_s;
  wire              mem_we   = wr_word & !space_q;
  wire              cfg_we   = wr_word & space_q & cfg_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction state machine.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= ddr_link_pkg::D_IDLE;
      ca_q      <= '0;
      cnt_q     <= '0;
      refresh_q <= 1'b0;
      rd_q      <= 1'b0;
      space_q   <= 1'b0;
      lin_q     <= 1'b0;
      addr_q    <= '0;
      phase_q   <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_abort <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_abort <= 1'b0;
      unique case (st_q)
        ddr_link_pkg::D_IDLE: begin
          if (!cs_s) begin
            st_q      <= ddr_link_pkg::D_CA;
            cnt_q     <= '0;
            ca_q      <= '0;
            refresh_q <= refresh_req;
          end
        end
        ddr_link_pkg::D_CA: begin
          if (cs_s) begin
            st_q      <= ddr_link_pkg::D_IDLE;
            cmd_abort <= 1'b1;
          end else if (link_edge) begin
            ca_q  <= ca_next;
            cnt_q <= cnt_next;
            if (ca_done) begin
              st_q      <= ddr_link_pkg::D_LAT;
              rd_q      <= dec_read;
              space_q   <= dec_space;
              lin_q     <= dec_lin;
              addr_q    <= dec_addr;
              cmd_valid <= 1'b1;
            end
          end
        end
        ddr_link_pkg::D_LAT: begin
          if (cs_s) begin
            st_q <= ddr_link_pkg::D_IDLE;
          end else if (link_edge) begin
            cnt_q <= cnt_next;
            if (lat_done) begin
              st_q    <= ddr_link_pkg::D_DATA;
              phase_q <= 1'b0;
            end
          end
        end
        ddr_link_pkg::D_DATA: begin
          if (cs_s) begin
            st_q <= ddr_link_pkg::D_IDLE;
          end else if (link_edge) begin
            phase_q <= !phase_q;
            if (phase_q) begin
              addr_q <= ddr_link_pkg::next_word(addr_q, lin_q);
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers: refresh flag, read strobe and read data.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_q    <= '0;
      dq_oe_q <= 1'b0;
      ds_q    <= 1'b0;
      ds_oe_q <= 1'b0;
    end else if (cs_s) begin
      dq_oe_q <= 1'b0;
      ds_oe_q <= 1'b0;
      ds_q    <= 1'b0;
    end else begin
      unique case (st_q)
        ddr_link_pkg::D_IDLE: begin
          ds_oe_q <= 1'b1;
          ds_q    <= refresh_req;
        end
        ddr_link_pkg::D_CA: begin
          if (ca_done) begin
            ds_oe_q <= dec_read;
            ds_q    <= 1'b0;
          end
        end
        ddr_link_pkg::D_LAT: begin
          if (lat_done) begin
            dq_oe_q <= rd_q;
          end
        end
        ddr_link_pkg::D_DATA: begin
          if (link_edge & rd_q) begin
            dq_q <= phase_q ? rd_word[7:0] : rd_word[15:8];
            ds_q <= !phase_q;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path: byte A is held until byte B completes the word.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_q    <= '0;
      hi_en_q <= 1'b0;
      cfg_q   <= CFG_RESET;
    end else begin
      if (data_edg & !phase_q) begin
        hi_q    <= dq_s;
        hi_en_q <= !ds_s;
      end
      if (cfg_we) begin
        if (hi_en_q) begin
          cfg_q[15:8] <= hi_q;
        end
        if (lo_en) begin
          cfg_q[7:0] <= dq_s;
        end
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (mem_we) begin
      if (hi_en_q) begin
        mem_q[mem_idx][15:8] <= hi_q;
      end
      if (lo_en) begin
        mem_q[mem_idx][7:0] <= dq_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign bus.d_dq      = dq_q;
  assign bus.d_dq_oe   = dq_oe_q;
  assign bus.d_ds      = ds_q;
  assign bus.d_ds_oe   = ds_oe_q;
  assign cmd_read      = rd_q;
  assign cmd_reg       = space_q;
  assign cmd_linear    = lin_q;
  assign cmd_word_addr = addr_q;
  assign cfg_word      = cfg_q;

endmodule

/* File: src/ddr_bus_host.sv */
// Host controller end: runs one single-word transaction per software order.
// Assumes an AHB-Lite master with single word transfers; makes the link clock.
module ddr_bus_host (
  // System
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // Link
  ddr_link_if.host         bus
);

  ////////////////////////////////////////////////////////////////////////////
  // Register slave with zero wait states.

  ddr_link_pkg::host_state_t st_q;
  logic        wr_pend_q;
  logic [7:0]  wr_ofs_q;
  logic [3:1]  ctrl_q;
  logic [31:0] addr_q;
  logic [17:0] wdata_q;
  logic [15:0] rdata_q;
  logic        refresh_q;
  logic        ready_q;
  logic        resp_q;
  logic [31:0] rdat_q;

  wire        busy     = (st_q != ddr_link_pkg::H_IDLE);
  wire        take     = hsel & hready & htrans[1];
  wire        wr_ctrl  = wr_pend_q & (wr_ofs_q == ddr_link_pkg::OFS_CTRL);
  wire        go       = wr_ctrl & hwdata[ddr_link_pkg::CTRL_GO] & !busy;
  wire [31:0] status_w = {30'h0, refresh_q, busy};
  wire [31:0] rd_mux   = (haddr[7:0] == ddr_link_pkg::OFS_CTRL)   ? {28'h0, ctrl_q, 1'b0} :
                         (haddr[7:0] == ddr_link_pkg::OFS_ADDR)   ? addr_q :
                         (haddr[7:0] == ddr_link_pkg::OFS_WDATA)  ? {14'h0, wdata_q} :
                         (haddr[7:0] == ddr_link_pkg::OFS_RDATA)  ? {16'h0, rdata_q} :
                         (haddr[7:0] == ddr_link_pkg::OFS_STATUS) ? status_w : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= '0;
      rdat_q    <= '0;
      ready_q   <= 1'b0;
      resp_q    <= 1'b0;
      ctrl_q    <= '0;
      addr_q    <= '0;
      wdata_q   <= '0;
    end else begin
      ready_q   <= 1'b1;
      wr_pend_q <= take & hwrite;
      wr_ofs_q  <= haddr[7:0];
      if (take & !hwrite) begin
        rdat_q <= rd_mux;
      end
      if (wr_ctrl & !busy) begin
        ctrl_q <= hwdata[3:1];
      end
      if (wr_pend_q & !busy & (wr_ofs_q == ddr_link_pkg::OFS_ADDR)) begin
        addr_q <= hwdata;
      end
      if (wr_pend_q & !busy & (wr_ofs_q == ddr_link_pkg::OFS_WDATA)) begin
        wdata_q <= hwdata[17:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer.

  logic [7:0] dq_s;
  logic       ds_s;
  logic       ds_prev_q;
  logic [7:0] div_q;
  logic [7:0] edge_q;
  logic       rx_cnt_q;
  logic       cs_n_q;
  logic       ck_q;
  logic       ckn_q;
  logic [7:0] dq_q;
  logic       dq_oe_q;
  logic       ds_q;
  logic       ds_oe_q;

  pin_sync #(
    .W    (9),
    .INIT (9'h000)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({bus.rw_data_strobe, bus.dq}),
    .q     ({ds_s, dq_s})
  );

  // Command word: row bits from addr_q[31:3], zero in the reserved field.
  wire [47:0] ca_word  = {ctrl_q[ddr_link_pkg::CTRL_READ], ctrl_q[ddr_link_pkg::CTRL_SPACE],
                          ctrl_q[ddr_link_pkg::CTRL_LINEAR], addr_q[31:3], 13'h0,
                          addr_q[2:0]};
  wire [7:0]  first_d  = ddr_link_pkg::data_start(refresh_q);
  wire [7:0]  last_e   = first_d + 8'h02;
  wire [7:0]  nxt_e    = edge_q + 8'h01;
  // Bytes change two cycles after a clock edge, mid-way to the next one.
  wire        at_mid   = (div_q == 8'(ddr_link_pkg::CK_MID - 1));
  wire        at_turn  = (div_q == 8'(ddr_link_pkg::CK_HALF - 1));
  wire        is_ca    = (nxt_e <= 8'(ddr_link_pkg::CA_EDGES));
  wire [5:0]  ca_sh    = 6'(8 * (ddr_link_pkg::CA_EDGES - 32'(nxt_e)));
  wire [7:0]  ca_byte  = 8'(ca_word >> ca_sh);
  wire        is_wd    = !ctrl_q[ddr_link_pkg::CTRL_READ] & (nxt_e > first_d) &
                         (nxt_e <= last_e);
  wire        byte_b   = (nxt_e == last_e);
  wire [7:0]  wd_byte  = byte_b ? wdata_q[7:0] : wdata_q[15:8];
  wire        wd_mask  = byte_b ? wdata_q[ddr_link_pkg::WD_MASK_B] :
                                  wdata_q[ddr_link_pkg::WD_MASK_A];
  wire        rx_edge  = (ds_s != ds_prev_q) & (edge_q >= first_d);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= ddr_link_pkg::H_IDLE;
      div_q     <= '0;
      edge_q    <= '0;
      rx_cnt_q  <= 1'b0;
      ds_prev_q <= 1'b0;
      refresh_q <= 1'b0;
      rdata_q   <= '0;
      cs_n_q    <= 1'b1;
      ck_q      <= 1'b0;
      ckn_q     <= 1'b1;
      dq_q      <= '0;
      dq_oe_q   <= 1'b0;
      ds_q      <= 1'b0;
      ds_oe_q   <= 1'b0;
    end else begin
      ds_prev_q <= ds_s;
      unique case (st_q)
        ddr_link_pkg::H_IDLE: begin
          if (go) begin
            st_q     <= ddr_link_pkg::H_CLK;
            cs_n_q   <= 1'b0;
            div_q    <= '0;
            edge_q   <= '0;
            rx_cnt_q <= 1'b0;
          end
        end
        ddr_link_pkg::H_CLK: begin
          div_q <= at_turn ? 8'h00 : div_q + 8'h01;
          if (at_mid) begin
            if (is_ca) begin
              dq_q    <= ca_byte;
              dq_oe_q <= 1'b1;
            end else if (is_wd) begin
              dq_q    <= wd_byte;
              dq_oe_q <= 1'b1;
              ds_q    <= wd_mask;
              ds_oe_q <= 1'b1;
            end else begin
              dq_oe_q <= 1'b0;
            end
            if (nxt_e == 8'(ddr_link_pkg::ROW_EDGE)) begin
              refresh_q <= ds_s;
            end
          end
          if (at_turn) begin
            if (edge_q == last_e) begin
              dq_oe_q <= 1'b0;
              ds_oe_q <= 1'b0;
              st_q    <= ddr_link_pkg::H_WAIT;
            end else begin
              ck_q   <= !ck_q;
              ckn_q  <= ck_q;
              edge_q <= nxt_e;
            end
          end
        end
        ddr_link_pkg::H_WAIT: begin
          if (!ctrl_q[ddr_link_pkg::CTRL_READ] | (rx_edge & rx_cnt_q)) begin
            st_q   <= ddr_link_pkg::H_IDLE;
            cs_n_q <= 1'b1;
          end
        end
      endcase
      if (busy & ctrl_q[ddr_link_pkg::CTRL_READ] & rx_edge) begin
        rx_cnt_q <= 1'b1;
        if (rx_cnt_q) begin
          rdata_q[7:0] <= dq_s;
        end else begin
          rdata_q[15:8] <= dq_s;
        end
      end
    end
  end

  assign hreadyout                = ready_q;
  assign hrdata                   = rdat_q;
  assign hresp                    = resp_q;
  assign bus.cs_n                 = cs_n_q;
  assign bus.bus_clock            = ck_q;
  assign bus.bus_clock_complement = ckn_q;
  assign bus.h_dq                 = dq_q;
  assign bus.h_dq_oe              = dq_oe_q;
  assign bus.h_ds                 = ds_q;
  assign bus.h_ds_oe              = ds_oe_q;

endmodule

/* File: dv/ddr_link_chk.sv */
// Checker for the link between the host end and the device end.
// Assumes the bench wires it to the link interface and the host clock domain.
module ddr_link_chk (
  // System
  input wire logic       hclk,
  input wire logic       hresetn,
  // Link
  input wire logic       cs_n,
  input wire logic       bus_clock,
  input wire logic       bus_clock_complement,
  input wire logic [7:0] dq,
  input wire logic       h_dq_oe,
  input wire logic       h_ds_oe,
  input wire logic       d_dq_oe,
  input wire logic       d_ds_oe
);
  timeunit 1ns / 1ps;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  a_select_clock_low:
    assert property ($fell(cs_n) |-> !bus_clock) else $error("select fell with clock high");
  a_idle_clock_low:
    assert property (cs_n |-> !bus_clock) else $error("link clock moved while deselected");
  a_clock_complement:
    assert property (bus_clock_complement != bus_clock) else $error("clock pair not inverse");
  a_half_period:
    assert property ($rose(bus_clock) |-> bus_clock [*4] ##1 !bus_clock)
      else $error("link clock half period wrong");
  a_bytes_centred:
    assert property (h_dq_oe && $changed(bus_clock) |-> $stable(dq))
      else $error("host data moved on a clock edge");
  a_one_driver:
    assert property (!(h_dq_oe && d_dq_oe)) else $error("both ends drive data");
  a_data_with_strobe:
    assert property (d_dq_oe |-> d_ds_oe) else $error("device data without strobe");
  a_release_after:
    assert property ($rose(cs_n) |-> ##4 (!d_dq_oe && !d_ds_oe))
      else $error("device still drives after select rose");
  a_strobe_owner:
    assert property (d_ds_oe |-> !h_ds_oe) else $error("both ends drive strobe");
endmodule

/* File: dv/ddr_bus_cmd_addr_decode_tb.sv */
// Bench joining the host end and the device end over one link, ordered over AHB-Lite.
// Assumes the host makes the link clock and answers the bus with hreadyout.
module ddr_bus_cmd_addr_decode_tb;
  timeunit 1ns / 1ps;
  // Identification value is arbitrary.
  localparam logic [15:0] ID_V = 16'h5a01;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        refresh_req;
  logic        cmd_valid;
  logic        cmd_read;
  logic        cmd_reg;
  logic        cmd_linear;
  logic [31:0] cmd_word_addr;
  logic [15:0] cfg_word;
  logic        cmd_abort;
  logic        abort_seen = 1'b0;
  logic [34:0] cap;
  logic [47:0] ca;
  int          n_edge;
  int          n_errors;
  int          check_count;

  ddr_link_if link ();
  ddr_bus_host i_ddr_bus_host (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .bus(link));
  ddr_mem_device #(.ID_VALUE(ID_V)) i_ddr_mem_device (.hclk, .hresetn, .bus(link),
    .refresh_req, .cmd_valid, .cmd_read, .cmd_reg, .cmd_linear, .cmd_word_addr,
    .cmd_abort, .cfg_word);
  ddr_link_chk i_ddr_link_chk (.hclk, .hresetn, .cs_n(link.cs_n), .bus_clock(link.bus_clock),
    .bus_clock_complement(link.bus_clock_complement), .dq(link.dq), .h_dq_oe(link.h_dq_oe),
    .h_ds_oe(link.h_ds_oe), .d_dq_oe(link.d_dq_oe), .d_ds_oe(link.d_ds_oe));

  always #5 hclk = ~hclk;

  // Watch the wire: count clock edges per frame and gather the command bytes.
  always @(negedge link.cs_n) n_edge = 0;
  always @(link.bus_clock) begin
    if (link.cs_n === 1'b0) begin
      if (n_edge < 6) ca = {ca[39:0], link.dq};
      n_edge++;
    end
  end
  always @(posedge hclk) begin
    if (cmd_valid === 1'b1) cap <= {cmd_read, cmd_reg, cmd_linear, cmd_word_addr};
    if (cmd_abort === 1'b1) abort_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic transact(input logic [3:0] ctl, input logic [31:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    logic [31:0] st;
    cap = 'x;
    ahb(ddr_link_pkg::OFS_ADDR, 1'b1, a, rd);
    ahb(ddr_link_pkg::OFS_WDATA, 1'b1, wd, rd);
    ahb(ddr_link_pkg::OFS_CTRL, 1'b1, {28'h0, ctl | 4'h1}, rd);
    do ahb(ddr_link_pkg::OFS_STATUS, 1'b0, 32'h0, st);
    while (st[ddr_link_pkg::ST_BUSY] !== 1'b0 || $isunknown(cap));
    ahb(ddr_link_pkg::OFS_RDATA, 1'b0, 32'h0, rd);
    chk(ca, {ctl[1], ctl[2], ctl[3], a[31:3], 13'h0, a[2:0]});
    chk(48'(cap), 48'({ctl[1], ctl[2], ctl[3], a}));
    chk(48'(n_edge), 48'(ddr_link_pkg::ROW_EDGE + 2 +
        2 * ddr_link_pkg::LAT_CYCLES * (refresh_req ? 2 : 1)));
    chk(48'(st[ddr_link_pkg::ST_REFRESH]), 48'(refresh_req));
  endtask

  task automatic t_bus();
    logic [31:0] r;
    ahb(8'h14, 1'b1, 32'hffff_ffff, r);
    ahb(8'h14, 1'b0, 32'h0, r);
    chk(48'(r), 48'h0);
    chk(48'(hresp), 48'h0);
  endtask

  task automatic t_mem();
    logic [31:0] r;
    transact(4'h0, 32'ha5c3_3c5d, 32'h0000_beef, r);
    chk(48'(cmd_word_addr), 48'ha5c3_3c5e);
    transact(4'h2, 32'ha5c3_3c5d, 32'h0, r);
    chk(48'(r[15:0]), 48'hbeef);
    transact(4'h8, 32'h0000_0002, 32'h0000_1122, r);
    transact(4'h8, 32'h0000_0002, 32'h0002_3344, r);
    transact(4'ha, 32'h0000_0002, 32'h0, r);
    chk(48'(r[15:0]), 48'h1144);
    transact(4'h0, 32'h0000_0017, 32'h0000_5566, r);
    chk(48'(cmd_word_addr), 48'h10);
    transact(4'ha, 32'h0000_0017, 32'h0, r);
    chk(48'(r[15:0]), 48'h5566);
    chk(48'(cmd_word_addr), 48'h18);
  endtask

  task automatic t_reg();
    logic [31:0] r;
    chk(48'(cfg_word), 48'h0);
    transact(4'h6, 32'h0, 32'h0, r);
    chk(48'(r[15:0]), 48'(ID_V));
    transact(4'h4, 32'h1, 32'h0001_abcd, r);
    chk(48'(cfg_word), 48'hab00);
    transact(4'he, 32'h1, 32'h0, r);
    chk(48'(r[15:0]), 48'hab00);
  endtask

  task automatic t_refresh();
    logic [31:0] r;
    refresh_req <= 1'b1;
    @(posedge hclk);
    transact(4'h2, 32'ha5c3_3c5d, 32'h0, r);
    chk(48'(r[15:0]), 48'hbeef);
    refresh_req <= 1'b0;
    @(posedge hclk);
    chk(48'(abort_seen), 48'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    refresh_req = 1'b0;
    n_errors = 0;
    check_count = 0;
    n_edge = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_bus();
    t_mem();
    t_reg();
    t_refresh();
    conclude();
  end

  initial begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule
